/* inc/display_bank_pkg.sv */
package display_bank_pkg;

    // Register byte offsets
    localparam logic [7:0] off_output_freq    = 8'h00;
    localparam logic [7:0] off_output_volt    = 8'h04;
    localparam logic [7:0] off_output_amp     = 8'h08;
    localparam logic [7:0] off_output_power   = 8'h0c;
    localparam logic [7:0] off_dc_link_volt   = 8'h10;
    localparam logic [7:0] off_commanded_freq = 8'h14;
    localparam logic [7:0] off_present_fault  = 8'h18;
    localparam logic [7:0] off_heatsink_temp  = 8'h1c;
    localparam logic [7:0] off_drive_cond     = 8'h20;
    localparam logic [7:0] off_drive_kind     = 8'h24;
    localparam logic [7:0] off_firmware_rev   = 8'h28;
    localparam logic [7:0] off_terminal_input = 8'h2c;
    localparam logic [7:0] off_phase_angle    = 8'h30;
    localparam logic [7:0] off_service_probe  = 8'h34;
    localparam logic [7:0] off_preset_switch  = 8'h38;
    localparam logic [7:0] off_analog_percent = 8'h3c;
    localparam logic [7:0] off_hist_newest    = 8'h40;
    localparam logic [7:0] off_hist_middle    = 8'h44;
    localparam logic [7:0] off_hist_oldest    = 8'h48;
    localparam logic [7:0] off_fault_flags    = 8'h4c;
    localparam logic [7:0] off_display_select = 8'h50;

    // Fault flag fields
    localparam int fault_flash_bit   = 0;
    localparam int reprogram_pend_bit = 1;

    // Value limits in display units
    localparam logic [15:0] freq_max_tenths    = 16'h0960;
    localparam logic [15:0] angle_max_tenths   = 16'h0708;
    localparam logic [15:0] dc_max_230         = 16'h0190;
    localparam logic [15:0] dc_max_460         = 16'h0320;
    localparam logic [15:0] analog_max_tenths  = 16'h05dc;
    localparam logic [7:0]  fault_code_max     = 8'h30;
    localparam logic [7:0]  reprogram_fault_code = 8'h30;
    localparam logic [7:0]  temp_floor         = 8'h45;
    localparam logic [7:0]  temp_ceiling       = 8'h96;
    localparam logic [3:0]  drive_cond_max     = 4'hb;
    localparam logic [4:0]  display_index_max  = 5'h13;
    localparam logic [4:0]  display_index_rst  = 5'h01;

    // AXI responses
    localparam logic [1:0] resp_okay   = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // Input mode encodings
    localparam logic [3:0] mode_three_wire = 4'h0;
    localparam logic [3:0] mode_preset     = 4'h8;

endpackage

/* hdl/drive_display_status_bank.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) All bank values are read-only to software
// (R2) Last selected display index kept, shown first
// (R3) Output frequency in 0.1 Hz, 0..240.0
// (R4) Output voltage whole volts, up to maximum
// (R5) Output current 0.01 A, up to 2x rated
// (R6) Output power 0.01 kW, up to 2x rated
// (R7) Bus volts: 400 cap 230V, 800 460V
// (R8) Commanded frequency from source or preset, 0.1Hz
// (R9) Active fault code limited to 0..48
// (R10) Flash while fault uncleared, zero once cleared
// (R11) Heatsink degrees 69..150, 69 means below 70
// (R12) Drive status four bits, 0000..1011
// (R13) Input status open 0, closed 1
// (R14) Three-wire: reverse, stop, start, analog polarity
// (R15) Preset mode: bit 3 shows extra preset terminal
// (R16) Power factor angle 0.1 degree, 0..180
// (R17) Preset switches shown, model sets width
// (R18) Analog percent minus zero offset, +-150.0
// (R19) Newest history ignores repeated fault code
// (R20) New fault shifts history down one place
// (R21) Restore defaults: newest 48, others zero
// (R22) Reprogram fault cleared by keypad or stop toggle
// (R23) Values sampled together on update strobe
// (R24) Service fields are fixed or diagnostic only
module drive_display_status_bank
    import display_bank_pkg::*;
#(
    parameter logic [15:0] drive_kind_id  = 16'h00a5, // Arbitrary value
    parameter logic [15:0] firmware_rev   = 16'h0001, // Arbitrary value
    parameter bit          is_460v_unit   = 1'b1,
    parameter bit          is_preset_model = 1'b0
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Measurement sources
    input  wire logic        update_strobe,
    input  wire logic [15:0] meas_output_freq,
    input  wire logic [15:0] meas_output_volt,
    input  wire logic [15:0] max_volt_limit,
    input  wire logic [15:0] meas_output_amp,
    input  wire logic [15:0] amp_limit_2x,
    input  wire logic [15:0] meas_output_power,
    input  wire logic [15:0] power_limit_2x,
    input  wire logic [15:0] meas_dc_link_volt,
    input  wire logic [15:0] source_freq,
    input  wire logic [15:0] preset_freq,
    input  wire logic        preset_active,
    input  wire logic [7:0]  meas_heatsink_temp,
    input  wire logic [3:0]  drive_condition_in,
    input  wire logic [15:0] meas_phase_angle,
    input  wire logic [15:0] service_probe_in,
    input  wire logic [15:0] analog_raw,
    input  wire logic [15:0] analog_zero_offset,
    // Terminal inputs and mode
    input  wire logic [3:0]  input_mode,
    input  wire logic        reverse_terminal,
    input  wire logic        stop_terminal,
    input  wire logic        start_terminal,
    input  wire logic        extra_preset_terminal,
    input  wire logic        analog_negative,
    input  wire logic        preset_switch_a,
    input  wire logic        preset_switch_b,
    input  wire logic        preset_switch_c,
    // Fault events
    input  wire logic        fault_event,
    input  wire logic [7:0]  fault_event_code,
    input  wire logic        fault_clear,
    input  wire logic        keypad_stop,
    input  wire logic        restore_defaults_action,
    // Display selection and nonvolatile storage
    input  wire logic        select_valid,
    input  wire logic [4:0]  select_index,
    input  wire logic        nv_load,
    input  wire logic [4:0]  nv_index,
    output logic [4:0]       nv_store_index,
    output logic             nv_store_strobe,
    output logic [4:0]       shown_index,
    output logic             fault_flash
);

    // Bus-side state
    logic        aw_held;
    logic        w_held;
    logic [7:0]  ar_addr;

    // Display registers
    logic [15:0] output_freq_value;
    logic [15:0] output_volt_value;
    logic [15:0] output_amp_value;
    logic [15:0] output_power_value;
    logic [15:0] dc_link_volt_value;
    logic [15:0] commanded_freq_value;
    logic [7:0]  present_fault_code;
    logic [7:0]  heatsink_temp_value;
    logic [3:0]  drive_condition_bits;
    logic [3:0]  terminal_input_bits;
    logic [15:0] phase_angle_value;
    logic [15:0] service_probe_value;
    logic [3:0]  preset_switch_bits;
    logic [15:0] analog_percent_value;
    logic [7:0]  fault_history_newest;
    logic [7:0]  fault_history_middle;
    logic [7:0]  fault_history_oldest;
    logic        reprogram_pending;
    logic        stop_prev;

    // Combinational samples
    logic [3:0]  next_terminal_bits;
    logic [15:0] next_analog;
    logic [7:0]  next_fault;
    logic signed [16:0] analog_diff;

    // Clamp to a ceiling
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
        clamp16 = (v > lim) ? lim : v;
    endfunction

    // Terminal status; bit 3 follows the input mode
    always_comb begin
        next_terminal_bits = {1'b0, start_terminal, stop_terminal, reverse_terminal}; // [R13]
        if (input_mode == mode_preset) begin
            next_terminal_bits[3] = extra_preset_terminal; // [R15]
        end else if (input_mode == mode_three_wire) begin
            next_terminal_bits[3] = analog_negative; // [R14]
        end else begin
            next_terminal_bits[3] = analog_negative;
        end
    end

    // Analog percent less zero offset, clamped
    always_comb begin
        analog_diff = $signed({analog_raw[15], analog_raw})
                    - $signed({analog_zero_offset[15], analog_zero_offset}); // [R18]
        if (analog_diff > $signed({1'b0, analog_max_tenths})) begin
            next_analog = analog_max_tenths;
        end else if (analog_diff < -$signed({1'b0, analog_max_tenths})) begin
            next_analog = 16'(-$signed({1'b0, analog_max_tenths}));
        end else begin
            next_analog = analog_diff[15:0];
        end
    end

    // Fault code limited to range
    always_comb begin
        next_fault = (fault_event_code > fault_code_max) ? fault_code_max : fault_event_code; // [R9]
    end

    // Sample measurements on the update strobe, analog percent in non-preset models only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_freq_value    <= 16'h0;
            output_volt_value    <= 16'h0;
            output_amp_value     <= 16'h0;
            output_power_value   <= 16'h0;
            dc_link_volt_value   <= 16'h0;
            commanded_freq_value <= 16'h0;
            heatsink_temp_value  <= temp_floor;
            drive_condition_bits <= 4'h0;
            terminal_input_bits  <= 4'h0;
            phase_angle_value    <= 16'h0;
            service_probe_value  <= 16'h0;
            preset_switch_bits   <= 4'h0;
            analog_percent_value <= 16'h0;
        end else if (update_strobe) begin // [R23]
            output_freq_value  <= clamp16(meas_output_freq, freq_max_tenths); // [R3]
            output_volt_value  <= clamp16(meas_output_volt, max_volt_limit); // [R4]
            output_amp_value   <= clamp16(meas_output_amp, amp_limit_2x); // [R5]
            output_power_value <= clamp16(meas_output_power, power_limit_2x); // [R6]
            dc_link_volt_value <= clamp16(meas_dc_link_volt,
                                          is_460v_unit ? dc_max_460 : dc_max_230); // [R7]
            commanded_freq_value <= clamp16(preset_active ? preset_freq : source_freq,
                                            freq_max_tenths); // [R8]
            // Anything below 70 C reads as the floor value
            if (meas_heatsink_temp < temp_floor + 8'h01) begin
                heatsink_temp_value <= temp_floor; // [R11]
            end else if (meas_heatsink_temp > temp_ceiling) begin
                heatsink_temp_value <= temp_ceiling;
            end else begin
                heatsink_temp_value <= meas_heatsink_temp;
            end
            drive_condition_bits <= (drive_condition_in > drive_cond_max)
                                    ? drive_cond_max : drive_condition_in; // [R12]
            terminal_input_bits  <= next_terminal_bits;
            phase_angle_value    <= clamp16(meas_phase_angle, angle_max_tenths); // [R16]
            service_probe_value  <= service_probe_in; // [R24]
            preset_switch_bits   <= {1'b0, is_preset_model & preset_switch_c,
                                     preset_switch_b, preset_switch_a}; // [R17]
            if (!is_preset_model) begin
                analog_percent_value <= next_analog;
            end
        end
    end

    // Active fault code and flash
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            present_fault_code <= 8'h00;
            fault_flash        <= 1'b0;
        end else if (fault_event) begin // Set wins over clear
            present_fault_code <= next_fault;
            fault_flash        <= 1'b1; // [R10]
        end else if (restore_defaults_action) begin
            present_fault_code <= reprogram_fault_code;
            fault_flash        <= 1'b1;
        end else if (fault_clear || (reprogram_pending && (keypad_stop
                     || (stop_terminal != stop_prev)))) begin
            present_fault_code <= 8'h00; // [R10]
            fault_flash        <= 1'b0;
        end
    end

    // Reprogram fault pending until stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reprogram_pending <= 1'b0;
            stop_prev         <= 1'b0;
        end else begin
            stop_prev <= stop_terminal;
            if (restore_defaults_action) begin
                reprogram_pending <= 1'b1;
            end else if (keypad_stop || (stop_terminal != stop_prev)) begin
                reprogram_pending <= 1'b0; // [R22]
            end
        end
    end

    // Fault history shift chain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_history_newest <= 8'h00;
            fault_history_middle <= 8'h00;
            fault_history_oldest <= 8'h00;
        end else if (restore_defaults_action) begin
            fault_history_newest <= reprogram_fault_code; // [R21]
            fault_history_middle <= 8'h00;
            fault_history_oldest <= 8'h00;
        end else if (fault_event && next_fault != fault_history_newest) begin // [R19]
            fault_history_oldest <= fault_history_middle; // [R20]
            fault_history_middle <= fault_history_newest;
            fault_history_newest <= next_fault;
        end
    end

    // Displayed index, restored from storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shown_index     <= display_index_rst;
            nv_store_index  <= display_index_rst;
            nv_store_strobe <= 1'b0;
        end else begin
            nv_store_strobe <= 1'b0;
            if (nv_load && nv_index != 5'h00 && nv_index <= display_index_max) begin
                shown_index <= nv_index; // [R2]
            end else if (select_valid && select_index != 5'h00
                         && select_index <= display_index_max) begin
                shown_index     <= select_index;
                nv_store_index  <= select_index; // [R2]
                nv_store_strobe <= 1'b1;
            end
        end
    end

    // Write channel: discard, answer with error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= resp_okay;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= resp_slverr; // [R1]
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: take address, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= resp_okay;
            ar_addr       <= 8'h00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr      <= s_axi_araddr;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= resp_okay;
                case (s_axi_araddr)
                    off_output_freq:    s_axi_rdata <= {16'h0, output_freq_value};
                    off_output_volt:    s_axi_rdata <= {16'h0, output_volt_value};
                    off_output_amp:     s_axi_rdata <= {16'h0, output_amp_value};
                    off_output_power:   s_axi_rdata <= {16'h0, output_power_value};
                    off_dc_link_volt:   s_axi_rdata <= {16'h0, dc_link_volt_value};
                    off_commanded_freq: s_axi_rdata <= {16'h0, commanded_freq_value};
                    off_present_fault:  s_axi_rdata <= {24'h0, present_fault_code};
                    off_heatsink_temp:  s_axi_rdata <= {24'h0, heatsink_temp_value};
                    off_drive_cond:     s_axi_rdata <= {28'h0, drive_condition_bits};
                    off_drive_kind:     s_axi_rdata <= {16'h0, drive_kind_id}; // [R24]
                    off_firmware_rev:   s_axi_rdata <= {16'h0, firmware_rev}; // [R24]
                    off_terminal_input: s_axi_rdata <= {28'h0, terminal_input_bits};
                    off_phase_angle:    s_axi_rdata <= {16'h0, phase_angle_value};
                    off_service_probe:  s_axi_rdata <= {16'h0, service_probe_value};
                    off_preset_switch:  s_axi_rdata <= {28'h0, preset_switch_bits};
                    off_analog_percent: s_axi_rdata <= {{16{analog_percent_value[15]}},
                                                        analog_percent_value};
                    off_hist_newest:    s_axi_rdata <= {24'h0, fault_history_newest};
                    off_hist_middle:    s_axi_rdata <= {24'h0, fault_history_middle};
                    off_hist_oldest:    s_axi_rdata <= {24'h0, fault_history_oldest};
                    off_fault_flags:    s_axi_rdata <= {30'h0, reprogram_pending,
                                                        fault_flash};
                    off_display_select: s_axi_rdata <= {27'h0, shown_index};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= resp_slverr;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* dv/drive_display_status_bank_asserts.sv */
`timescale 1ns/1ps
module display_bank_checker
    import display_bank_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Fault and selection
    input wire logic        fault_event,
    input wire logic [7:0]  fault_event_code,
    input wire logic        restore_defaults_action,
    input wire logic        select_valid,
    input wire logic [4:0]  select_index,
    input wire logic        nv_load,
    input wire logic [4:0]  nv_index,
    input wire logic [4:0]  shown_index,
    input wire logic        fault_flash
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_WRITE_REFUSED: assert property (s_axi_bvalid |-> s_axi_bresp == resp_slverr)
        else $error("write not refused");
    AST_BRESP_HELD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_READ_COHERENT: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata not held");
    AST_READ_ANSWER: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
        else $error("no read answer");
    AST_FAULT_FLASH: assert property (
        fault_event && fault_event_code != 8'h00 |=> fault_flash[*2])
        else $error("no flash on fault");
    AST_RESTORE_FLASH: assert property (restore_defaults_action |=> fault_flash)
        else $error("no flash on restore");
    AST_SELECT_SHOWN: assert property (
        select_valid && select_index inside {[5'h01:5'h13]}
        |=> shown_index == $past(select_index))
        else $error("select not shown");
    AST_LOAD_SHOWN: assert property (
        nv_load && nv_index inside {[5'h01:5'h13]} |=> shown_index == $past(nv_index))
        else $error("load not shown");
endmodule

/* dv/drive_display_status_bank_test.sv */
`timescale 1ns/1ps
module drive_display_status_bank_test;
    import display_bank_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, update_strobe = 1'b0;
    logic preset_active = 1'b0, reverse_terminal = 1'b0, stop_terminal = 1'b1;
    logic start_terminal = 1'b0, extra_preset_terminal = 1'b0, analog_negative = 1'b0;
    logic preset_switch_a = 1'b0, preset_switch_b = 1'b0, preset_switch_c = 1'b0;
    logic fault_event = 1'b0, fault_clear = 1'b0, keypad_stop = 1'b0;
    logic restore_defaults_action = 1'b0, select_valid = 1'b0, nv_load = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, fault_event_code = '0;
    logic [7:0] meas_heatsink_temp = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf, drive_condition_in = '0, input_mode = '0;
    logic [15:0] meas_output_freq = '0, meas_output_volt = '0, meas_output_amp = '0;
    logic [15:0] meas_output_power = '0, meas_dc_link_volt = '0, source_freq = '0;
    logic [15:0] preset_freq = '0, meas_phase_angle = '0, service_probe_in = '0;
    logic [15:0] analog_raw = '0, analog_zero_offset = '0, max_volt_limit = 16'h01fe;
    logic [15:0] amp_limit_2x = 16'h03e8, power_limit_2x = 16'h03e8;
    logic [4:0] select_index = '0, nv_index = '0;
    logic [31:0] s_axi_rdata, rd_data;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [4:0] nv_store_index, shown_index;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic nv_store_strobe, fault_flash;
    int n_mismatch = 0, n_compared = 0;
    localparam logic [15:0] kind_id = 16'h0033; // Arbitrary value

    drive_display_status_bank #(.drive_kind_id(kind_id)) dut_u (.*);

    // Clock at 200 MHz
    always #2.5 aclk = ~aclk;

    task automatic step;
        @(posedge aclk);
    endtask

    // Value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus read
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do step; while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) step;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(rd_data, exp);
    endtask

    // Bus write
    task automatic wr(input logic [7:0] a);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'h555;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            step;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic strobe;
        update_strobe <= 1'b1;
        step;
        update_strobe <= 1'b0;
        step;
    endtask

    task automatic flt(input logic [7:0] c);
        fault_event <= 1'b1;
        fault_event_code <= c;
        step;
        fault_event <= 1'b0;
        step;
    endtask

    task automatic test_values;
        meas_output_freq <= 16'h0960;
        meas_output_volt <= 16'h01cc;
        meas_output_amp <= 16'h01f4;
        meas_output_power <= 16'h00c8;
        meas_dc_link_volt <= 16'h0320;
        meas_phase_angle <= 16'h0708;
        source_freq <= 16'h0258;
        meas_heatsink_temp <= 8'h28;
        drive_condition_in <= 4'hb;
        service_probe_in <= 16'h5a5a;
        analog_raw <= 16'h0064;
        analog_zero_offset <= 16'h001e;
        strobe;
        rchk(off_output_freq, 32'h0960);
        rchk(off_output_volt, 32'h01cc);
        rchk(off_output_amp, 32'h01f4);
        rchk(off_output_power, 32'h00c8);
        rchk(off_dc_link_volt, 32'h0320);
        rchk(off_phase_angle, 32'h0708);
        rchk(off_commanded_freq, 32'h0258);
        rchk(off_heatsink_temp, 32'h45);
        rchk(off_drive_cond, 32'hb);
        rchk(off_service_probe, 32'h5a5a);
        rchk(off_drive_kind, {16'h0, kind_id});
        rchk(off_analog_percent, 32'h46);
        preset_active <= 1'b1;
        preset_freq <= 16'h0123;
        meas_heatsink_temp <= 8'h96;
        analog_raw <= 16'hffce;
        analog_zero_offset <= 16'h0000;
        strobe;
        rchk(off_commanded_freq, 32'h0123);
        rchk(off_heatsink_temp, 32'h96);
        rchk(off_analog_percent, 32'hffff_ffce);
        wr(off_output_freq);
        chk({30'h0, wr_resp}, {30'h0, resp_slverr});
        rchk(off_output_freq, 32'h0960);
        rchk(8'h7c, 32'h0);
        chk({30'h0, rd_resp}, {30'h0, resp_slverr});
        $display("test values done");
    endtask

    task automatic test_inputs;
        reverse_terminal <= 1'b1;
        analog_negative <= 1'b1;
        preset_switch_a <= 1'b1;
        preset_switch_b <= 1'b1;
        preset_switch_c <= 1'b1;
        strobe;
        rchk(off_terminal_input, 32'hb);
        rchk(off_preset_switch, 32'h3);
        input_mode <= mode_preset;
        strobe;
        rchk(off_terminal_input, 32'h3);
        $display("test inputs done");
    endtask

    task automatic test_faults;
        flt(8'h05);
        rchk(off_hist_newest, 32'h05);
        chk({31'h0, fault_flash}, 32'h1);
        flt(8'h05);
        flt(8'h07);
        flt(8'h09);
        rchk(off_hist_newest, 32'h09);
        rchk(off_hist_middle, 32'h07);
        rchk(off_hist_oldest, 32'h05);
        rchk(off_present_fault, 32'h09);
        fault_clear <= 1'b1;
        step;
        fault_clear <= 1'b0;
        step;
        rchk(off_present_fault, 32'h0);
        restore_defaults_action <= 1'b1;
        step;
        restore_defaults_action <= 1'b0;
        step;
        rchk(off_hist_newest, {24'h0, reprogram_fault_code});
        rchk(off_hist_middle, 32'h0);
        rchk(off_hist_oldest, 32'h0);
        rchk(off_fault_flags, 32'h3);
        stop_terminal <= 1'b0;
        step;
        stop_terminal <= 1'b1;
        step;
        rchk(off_fault_flags, 32'h0);
        restore_defaults_action <= 1'b1;
        step;
        restore_defaults_action <= 1'b0;
        keypad_stop <= 1'b1;
        step;
        keypad_stop <= 1'b0;
        step;
        rchk(off_fault_flags, 32'h0);
        $display("test faults done");
    endtask

    task automatic test_select;
        select_valid <= 1'b1;
        select_index <= 5'h07;
        step;
        select_valid <= 1'b0;
        step;
        chk({31'h0, nv_store_strobe}, 32'h1);
        step;
        rchk(off_display_select, 32'h07);
        chk({27'h0, nv_store_index}, 32'h07);
        nv_load <= 1'b1;
        nv_index <= 5'h13;
        step;
        nv_load <= 1'b0;
        select_valid <= 1'b1;
        select_index <= 5'h14;
        step;
        select_valid <= 1'b0;
        step;
        rchk(off_display_select, 32'h13);
        $display("test select done");
    endtask

    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) step;
        aresetn <= 1'b1;
        rchk(off_heatsink_temp, 32'h45);
        rchk(off_display_select, 32'h01);
        rchk(off_fault_flags, 32'h0);
        $display("test reset done");
        test_values;
        test_inputs;
        test_faults;
        test_select;
        complete_run;
    end

    // Watchdog
    initial begin
        #100000;
        n_mismatch++;
        $display("ERROR at %0t: timeout", $time);
        complete_run;
    end
endmodule

bind drive_display_status_bank display_bank_checker chk_u (.*);
